// ===== common/therm_pkg.sv
// shared constants and types for the thermometer link, device end and host end
package therm_pkg;

   // ****************************************
   // clock and conversion timing
   // ****************************************
   localparam int unsigned CLK_HZ            = 125_000_000;
   localparam int unsigned CONV_TIME_SLOW_MS = 500;
   localparam int unsigned CONV_TIME_FAST_MS = 15;
   localparam int unsigned CONV_CYC_SLOW     = (CLK_HZ / 1000) * CONV_TIME_SLOW_MS;
   localparam int unsigned CONV_CYC_FAST     = (CLK_HZ / 1000) * CONV_TIME_FAST_MS;
   localparam int unsigned CONV_CNT_W        = 26;

   // ****************************************
   // slot timing in core_clk cycles
   // ****************************************
   localparam logic [7:0] SLOT_CYC      = 8'h10;
   localparam logic [7:0] HOST_SLOT_CYC = 8'h14;
   localparam logic [7:0] LOW1_CYC      = 8'h02;
   localparam logic [7:0] LOW0_CYC      = 8'h0A;
   localparam logic [7:0] SAMPLE_CYC    = 8'h05;
   localparam logic [7:0] RESET_CYC     = 8'h40;
   localparam logic [7:0] RESET_DET_CYC = 8'h28;
   localparam logic [7:0] RECOVER_CYC   = 8'h10;

   // ****************************************
   // command codes
   // ****************************************
   localparam logic [7:0] CMD_CONVERT      = 8'h44;
   localparam logic [7:0] CMD_ALARM_SEARCH = 8'hEC;
   localparam logic [7:0] CMD_WRITE_SP     = 8'h4E;
   localparam logic [7:0] CMD_READ_SP      = 8'hBE;

   // ****************************************
   // scratchpad and result layout
   // ****************************************
   localparam int unsigned SP_READ_BITS     = 40;
   localparam int unsigned SP_WRITE_BITS    = 24;
   localparam int unsigned ID_W             = 64;
   localparam int unsigned RES_SEL_POS_LOW  = 5;
   localparam int unsigned RES_SEL_POS_HIGH = 6;
   localparam logic [1:0]  RES_SEL_RESET    = 2'h3;
   localparam int unsigned TEMP_CMP_HI      = 11;
   localparam int unsigned TEMP_CMP_LO      = 4;

   typedef enum logic [1:0] {
      RES_9  = 2'b00,
      RES_10 = 2'b01,
      RES_11 = 2'b10,
      RES_12 = 2'b11
   } res_t;

   typedef enum logic [2:0] {
      ST_CMD    = 3'b000,
      ST_POLL   = 3'b001,
      ST_WRITE  = 3'b010,
      ST_READ   = 3'b011,
      ST_SEARCH = 3'b100,
      ST_DONE   = 3'b101
   } dev_state_t;

   // ****************************************
   // host register map
   // ****************************************
   localparam logic [3:0] HOST_REG_CMD    = 4'h0;
   localparam logic [3:0] HOST_REG_STATUS = 4'h4;
   localparam int unsigned CMD_DATA_POS   = 8;
   localparam int unsigned STAT_DATA_POS  = 8;

   typedef enum logic [1:0] {
      OP_NONE  = 2'b00,
      OP_RESET = 2'b01,
      OP_WRITE = 2'b10,
      OP_READ  = 2'b11
   } host_op_t;

endpackage : therm_pkg

// ===== common/therm_if.sv
// open-drain data line between bus master and thermometer
`timescale 1ns/1ps
interface therm_if;
   logic host_oe;
   logic host_out;
   logic dev_oe;
   logic dev_out;
   logic line;

   // wired-and of both drivers with pull-up
   assign line = ~((host_oe & ~host_out) | (dev_oe & ~dev_out));

   modport host (
      output host_oe,
      output host_out,
      input  line
   );

   modport device (
      output dev_oe,
      output dev_out,
      input  line
   );
endinterface : therm_if

// ===== verilog/slot_listener.sv
// device-side slot detector, bit sampler and bus reset detector
`timescale 1ns/1ps
module slot_listener (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // line
   input  wire logic line_in,
   input  wire logic tx_zero,
   output logic      line_oe,
   // decoded events
   output logic      bit_strobe,
   output logic      bit_value,
   output logic      bus_reset
);
   import therm_pkg::*;

   logic       line_q;
   logic       in_slot;
   logic [7:0] cnt;
   logic [7:0] low_cnt;
   logic       fall;

   assign fall = line_q & ~line_in;

   always_ff @(posedge core_clk) begin
      if (!rst_n) line_q <= 1'b1;
      else        line_q <= line_in;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         in_slot <= 1'b0;
         cnt     <= 8'h00;
      end else if (fall && !in_slot) begin
         in_slot <= 1'b1;
         cnt     <= 8'h01;
      end else if (in_slot) begin
         if (cnt == SLOT_CYC - 8'h01) in_slot <= 1'b0;
         cnt <= cnt + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         bit_strobe <= 1'b0;
         bit_value  <= 1'b1;
      end else begin
         bit_strobe <= in_slot && (cnt == SAMPLE_CYC);
         bit_value  <= line_in;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) line_oe <= 1'b0;
      else        line_oe <= (tx_zero & fall & ~in_slot) | (line_oe & in_slot & (cnt < LOW0_CYC - 8'h01));
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         low_cnt   <= 8'h00;
         bus_reset <= 1'b0;
      end else begin
         bus_reset <= 1'b0;
         if (line_in) low_cnt <= 8'h00;
         else if (low_cnt != 8'hFF) begin
            low_cnt   <= low_cnt + 8'h01;
            bus_reset <= (low_cnt == RESET_DET_CYC);
         end
      end
   end
endmodule : slot_listener

// ===== verilog/therm_device.sv
// thermometer device end: command decode, conversion, result and alarm
`timescale 1ns/1ps
module therm_device #(
   parameter logic                  FAST_VARIANT  = 1'b0,
   parameter logic                  EXT_14BIT     = 1'b0,
   parameter logic [63:0]           DEVICE_ID     = 64'h0123_4567_89AB_CD01, // arbitrary value
   parameter logic [7:0]            UPPER_INIT    = 8'h7F,
   parameter logic [7:0]            LOWER_INIT    = 8'h80,
   parameter logic [therm_pkg::CONV_CNT_W-1:0] CONV_CYC_SLOW = therm_pkg::CONV_CYC_SLOW[therm_pkg::CONV_CNT_W-1:0],
   parameter logic [therm_pkg::CONV_CNT_W-1:0] CONV_CYC_FAST = therm_pkg::CONV_CYC_FAST[therm_pkg::CONV_CNT_W-1:0]
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // link
   therm_if.device          link,
   // sensor front end
   input  wire logic [11:0] sensor_value,
   input  wire logic [1:0]  sensor_frac,
   // observed state
   output logic [15:0]      temperature_result,
   output logic             alarm_flag,
   output logic             conv_busy
);
   import therm_pkg::*;

   // ****************************************
   // declarations
   // ****************************************
   logic [CONV_CNT_W-1:0] conv_cnt;
   logic [CONV_CNT_W-1:0] conv_limit;
   logic                  conv_start;
   logic                  conv_done;
   logic [7:0]            upper_alarm_limit;
   logic [7:0]            lower_alarm_limit;
   logic                  resolution_sel_low;
   logic                  resolution_sel_high;
   dev_state_t            state;
   logic [6:0]            bit_cnt;
   logic [23:0]           sh;
   logic [23:0]           next_sh;
   logic [15:0]           next_result;
   logic [7:0]            config_byte;
   logic [39:0]           sp_bits;
   logic                  tx_zero;
   logic                  bit_strobe;
   logic                  bit_value;
   logic                  bus_reset;
   logic                  line_oe;

   // ****************************************
   // result formatting
   // ****************************************
   function automatic logic [15:0] build_result(
      input logic [11:0] v,
      input logic [1:0]  f,
      input logic [1:0]  r,
      input logic        ext
   );
      logic [15:0] t;
      t = {{4{v[11]}}, v};
      if (ext) begin
         t[15:14] = f;
      end else begin
         unique case (r)
            RES_9:  t[2:0] = 3'h0;
            RES_10: t[1:0] = 2'h0;
            RES_11: t[0]   = 1'b0;
            RES_12: t      = t;
         endcase
      end
      return t;
   endfunction : build_result

   assign next_result = build_result(sensor_value, sensor_frac,
                                     {resolution_sel_high, resolution_sel_low}, EXT_14BIT);

   // ****************************************
   // slot engine
   // ****************************************
   slot_listener u_slot (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .line_in    (link.line),
      .tx_zero    (tx_zero),
      .line_oe    (line_oe),
      .bit_strobe (bit_strobe),
      .bit_value  (bit_value),
      .bus_reset  (bus_reset)
   );

   assign link.dev_oe  = line_oe;
   assign link.dev_out = 1'b0;

   // ****************************************
   // conversion timer
   // ****************************************
   assign conv_limit = FAST_VARIANT ? CONV_CYC_FAST : CONV_CYC_SLOW;
   assign conv_done  = conv_busy && (conv_cnt == conv_limit - 1'b1);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         conv_busy <= 1'b0;
         conv_cnt  <= '0;
      end else if (conv_start && !conv_busy) begin
         conv_busy <= 1'b1;
         conv_cnt  <= '0;
      end else if (conv_done) begin
         conv_busy <= 1'b0;
      end else if (conv_busy) begin
         conv_cnt  <= conv_cnt + 1'b1;
      end
   end

   // ****************************************
   // result and alarm
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         temperature_result <= 16'h0000;
         alarm_flag         <= 1'b0;
      end else if (conv_done) begin
         temperature_result <= next_result;
         alarm_flag <= ($signed(next_result[TEMP_CMP_HI:TEMP_CMP_LO]) <= $signed(lower_alarm_limit)) ||
                       ($signed(next_result[TEMP_CMP_HI:TEMP_CMP_LO]) >= $signed(upper_alarm_limit));
      end
   end

   // ****************************************
   // scratchpad view
   // ****************************************
   assign config_byte = {1'b0, resolution_sel_high, resolution_sel_low, 5'h00};
   assign sp_bits     = {config_byte, lower_alarm_limit, upper_alarm_limit,
                         temperature_result[15:8], temperature_result[7:0]};

   always_comb begin
      unique case (state)
         ST_POLL:   tx_zero = conv_busy;
         ST_READ:   tx_zero = ~sp_bits[bit_cnt[5:0]];
         ST_SEARCH: tx_zero = ~DEVICE_ID[bit_cnt[5:0]];
         default:   tx_zero = 1'b0;
      endcase
   end

   // ****************************************
   // command sequencer
   // ****************************************
   assign next_sh    = {bit_value, sh[23:1]};
   assign conv_start = bit_strobe && (state == ST_CMD) && (bit_cnt == 7'h07) &&
                       (next_sh[23:16] == CMD_CONVERT);

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state   <= ST_CMD;
         bit_cnt <= 7'h00;
         sh      <= 24'h000000;
      end else if (bus_reset) begin
         state   <= ST_CMD;
         bit_cnt <= 7'h00;
      end else if (bit_strobe) begin
         sh      <= next_sh;
         bit_cnt <= bit_cnt + 7'h01;
         unique case (state)
            ST_CMD: begin
               if (bit_cnt == 7'h07) begin
                  bit_cnt <= 7'h00;
                  unique case (next_sh[23:16])
                     CMD_CONVERT:      state <= ST_POLL;
                     CMD_WRITE_SP:     state <= ST_WRITE;
                     CMD_READ_SP:      state <= ST_READ;
                     CMD_ALARM_SEARCH: state <= alarm_flag ? ST_SEARCH : ST_DONE;
                     default:          state <= ST_DONE;
                  endcase
               end
            end
            ST_WRITE: begin
               if (bit_cnt == 7'(SP_WRITE_BITS - 1)) state <= ST_DONE;
            end
            ST_READ: begin
               if (bit_cnt == 7'(SP_READ_BITS - 1)) state <= ST_DONE;
            end
            ST_SEARCH: begin
               if (bit_cnt == 7'(ID_W - 1)) state <= ST_DONE;
            end
            ST_POLL: bit_cnt <= 7'h00;
            ST_DONE: bit_cnt <= 7'h00;
            default: state   <= ST_DONE;
         endcase
      end
   end

   // ****************************************
   // limits and configuration
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         upper_alarm_limit   <= UPPER_INIT;
         lower_alarm_limit   <= LOWER_INIT;
         resolution_sel_low  <= RES_SEL_RESET[0];
         resolution_sel_high <= RES_SEL_RESET[1];
      end else if (bit_strobe && !bus_reset && (state == ST_WRITE) &&
                   (bit_cnt == 7'(SP_WRITE_BITS - 1))) begin
         upper_alarm_limit   <= next_sh[7:0];
         lower_alarm_limit   <= next_sh[15:8];
         resolution_sel_low  <= next_sh[16 + RES_SEL_POS_LOW];
         resolution_sel_high <= next_sh[16 + RES_SEL_POS_HIGH];
      end
   end

endmodule : therm_device

// ===== verilog/therm_host.sv
// bus master end: avalon-mm command registers driving reset, write and read slots
`timescale 1ns/1ps
module therm_host (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // link
   therm_if.host            link,
   // avalon-mm slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest
);
   import therm_pkg::*;

   logic       resp;
   logic       busy;
   host_op_t   op;
   logic [7:0] tx_byte;
   logic [7:0] rx_byte;
   logic [2:0] bit_cnt;
   logic [7:0] cnt;
   logic [7:0] low_len;
   logic       wr_take;

   // ****************************************
   // bus slave
   // ****************************************
   assign waitrequest = (read | write) & ~resp;
   assign wr_take     = write & resp & (address == HOST_REG_CMD) & ~busy &
                        (host_op_t'(writedata[1:0]) != OP_NONE);

   always_ff @(posedge core_clk) begin
      if (!rst_n) resp <= 1'b0;
      else        resp <= (read | write) & ~resp;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) readdata <= 32'h00000000;
      else if (read && !resp) begin
         if (address == HOST_REG_STATUS) readdata <= {16'h0000, rx_byte, 7'h00, busy};
         else                            readdata <= 32'h00000000;
      end
   end

   // ****************************************
   // slot generator
   // ****************************************
   assign low_len = (op == OP_WRITE && !tx_byte[0]) ? LOW0_CYC : LOW1_CYC;
   assign link.host_out = 1'b0;
   assign link.host_oe  = busy && ((op == OP_RESET) ? (cnt < RESET_CYC) : (cnt < low_len));

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         busy    <= 1'b0;
         op      <= OP_NONE;
         tx_byte <= 8'h00;
         rx_byte <= 8'h00;
         bit_cnt <= 3'h0;
         cnt     <= 8'h00;
      end else if (wr_take) begin
         busy    <= 1'b1;
         op      <= host_op_t'(writedata[1:0]);
         tx_byte <= writedata[CMD_DATA_POS +: 8];
         bit_cnt <= 3'h0;
         cnt     <= 8'h00;
      end else if (busy) begin
         cnt <= cnt + 8'h01;
         if (op == OP_RESET) begin
            if (cnt == RESET_CYC + RECOVER_CYC - 8'h01) busy <= 1'b0;
         end else begin
            if (cnt == SAMPLE_CYC) rx_byte <= {link.line, rx_byte[7:1]};
            if (cnt == HOST_SLOT_CYC - 8'h01) begin
               cnt     <= 8'h00;
               tx_byte <= {1'b0, tx_byte[7:1]};
               bit_cnt <= bit_cnt + 3'h1;
               if (bit_cnt == 3'h7) busy <= 1'b0;
            end
         end
      end
   end
endmodule : therm_host

// ===== verification/temp_convert_alarm_properties.sv
// concurrent checks on the link wire and the device's observed state
`timescale 1ns/1ps
module temp_convert_alarm_properties #(
   parameter int CONV_CYC = 200
) (
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // link
   input wire logic        host_oe,
   input wire logic        host_out,
   input wire logic        dev_oe,
   input wire logic        dev_out,
   input wire logic        line,
   // device state
   input wire logic [15:0] temperature_result,
   input wire logic        alarm_flag,
   input wire logic        conv_busy
);
   localparam int LEN_LO = CONV_CYC - 4;
   localparam int LEN_HI = CONV_CYC + 4;
   logic [15:0] busy_len;

   // ****************************************
   // busy length counter
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         busy_len <= 16'h0000;
      end else if (conv_busy) begin
         busy_len <= busy_len + 16'h0001;
      end else begin
         busy_len <= 16'h0000;
      end
   end

   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_idle_after_reset: assert property ($rose(rst_n) |-> !conv_busy && !dev_oe)
      else $error("device not idle after reset");
   a_conv_runs: assert property ($rose(conv_busy) |=> conv_busy [*8])
      else $error("conversion stopped early");
   a_conv_time: assert property ($fell(conv_busy) |-> int'(busy_len) >= LEN_LO && int'(busy_len) <= LEN_HI)
      else $error("conversion length wrong");
   a_reply_bounded: assert property ($rose(dev_oe) |-> ##[1:12] !dev_oe)
      else $error("device holds line too long");
   a_drivers_pull_low: assert property ($rose(dev_oe) |-> $past(host_oe) && !dev_out && !host_out)
      else $error("device drove line outside a host slot");
   a_released_high: assert property ((!host_oe && !dev_oe) |-> line)
      else $error("released line not high");
   a_sign_bits: assert property (temperature_result[15:11] == {5{temperature_result[11]}})
      else $error("sign bits differ");
   a_update_at_end: assert property (($changed(temperature_result) || $changed(alarm_flag))
      |-> ($past(conv_busy) || $past(conv_busy, 2)))
      else $error("result changed outside completion");
endmodule : temp_convert_alarm_properties

// ===== verification/temp_convert_alarm_tb.sv
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
module temp_convert_alarm_tb;
   import therm_pkg::*;

   // ****************************************
   // signals and instances
   // ****************************************
   localparam logic [25:0] CONV   = 26'h00000C8;
   localparam logic [63:0] DEV_ID = 64'hC3D2_E1F0_1234_5678; // arbitrary value
   localparam logic [11:0] SV [7] = '{12'h197, 12'h197, 12'h197, 12'h197, 12'hF5E, 12'hF5E, 12'h7D0};
   localparam logic [1:0]  RS [7] = '{2'h3, 2'h2, 2'h1, 2'h0, 2'h3, 2'h3, 2'h3};
   localparam logic [7:0]  UP [7] = '{8'h19, 8'h19, 8'h1A, 8'h1A, 8'h7D, 8'h7D, 8'h7D};
   localparam logic [7:0]  LO [7] = '{8'h05, 8'h05, 8'h05, 8'h19, 8'hF5, 8'hF4, 8'hC9};
   logic        core_clk     = 1'b0;
   logic        rst_n        = 1'b0;
   logic [3:0]  address      = 4'h0;
   logic        read         = 1'b0;
   logic        write        = 1'b0;
   logic [31:0] writedata    = 32'h0;
   logic [11:0] sensor_value = 12'h000;
   logic [1:0]  sensor_frac  = 2'h0;
   logic [31:0] readdata;
   logic        waitrequest;
   logic [15:0] temperature_result;
   logic        alarm_flag;
   logic        conv_busy;
   int          fails        = 0;
   int          n_tests      = 0;

   always #4 core_clk = ~core_clk;

   therm_if therm_if_inst ();
   therm_device #(.DEVICE_ID(DEV_ID), .CONV_CYC_SLOW(CONV), .CONV_CYC_FAST(26'h0000032)) therm_device_inst (
      .core_clk(core_clk), .rst_n(rst_n), .link(therm_if_inst), .sensor_value(sensor_value),
      .sensor_frac(sensor_frac), .temperature_result(temperature_result), .alarm_flag(alarm_flag),
      .conv_busy(conv_busy));
   therm_host therm_host_inst (
      .core_clk(core_clk), .rst_n(rst_n), .link(therm_if_inst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
   temp_convert_alarm_properties #(.CONV_CYC(int'(CONV))) temp_convert_alarm_properties_inst (
      .core_clk(core_clk), .rst_n(rst_n), .host_oe(therm_if_inst.host_oe), .host_out(therm_if_inst.host_out),
      .dev_oe(therm_if_inst.dev_oe), .dev_out(therm_if_inst.dev_out), .line(therm_if_inst.line),
      .temperature_result(temperature_result), .alarm_flag(alarm_flag), .conv_busy(conv_busy));

   // ****************************************
   // tasks
   // ****************************************
   task automatic conclude;
      if (fails == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic stall;
      fails++;
      $display("BAD %0t wait ran out", $time);
      conclude();
   endtask : stall

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int i;
      address   <= a;
      writedata <= d;
      write     <= wr;
      read      <= ~wr;
      for (i = 0; i < 50; i++) begin
         @(posedge core_clk);
         if (waitrequest === 1'b0) break;
      end
      q = readdata;
      if (i == 50) stall();
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge core_clk);
   endtask : av_xfer

   task automatic op(input host_op_t o, input logic [7:0] b, output logic [7:0] r);
      logic [31:0] q;
      int          i;
      av_xfer(1'b1, HOST_REG_CMD, {16'h0000, b, 6'h00, o}, q);
      for (i = 0; i < 400; i++) begin
         av_xfer(1'b0, HOST_REG_STATUS, 32'h0, q);
         if (q[0] === 1'b0) break;
      end
      if (i == 400) stall();
      r = q[15:8];
   endtask : op

   task automatic cmd(input logic [7:0] c);
      logic [7:0] r;
      op(OP_RESET, 8'h00, r);
      op(OP_WRITE, c, r);
   endtask : cmd

   task automatic read_sp(input logic [39:0] e);
      logic [7:0] r;
      cmd(CMD_READ_SP);
      for (int k = 0; k < 5; k++) begin
         op(OP_READ, 8'h00, r);
         chk({8'h00, r}, {8'h00, e[8*k +: 8]}, "scratchpad byte");
      end
   endtask : read_sp

   task automatic run_case(input logic [11:0] sv, input logic [1:0] res, input logic [7:0] up, input logic [7:0] lo);
      logic [15:0] ex;
      logic [7:0]  r;
      logic        al;
      ex = {{4{sv[11]}}, sv} & ~((16'h0001 << (3 - res)) - 16'h0001);
      al = ($signed(ex[11:4]) <= $signed(lo)) || ($signed(ex[11:4]) >= $signed(up));
      sensor_value <= sv;
      cmd(CMD_WRITE_SP);
      op(OP_WRITE, up, r);
      op(OP_WRITE, lo, r);
      op(OP_WRITE, {1'b0, res, 5'h00}, r);
      cmd(CMD_CONVERT);
      op(OP_READ, 8'h00, r);
      chk({8'h00, r}, 16'h0000, "busy slots");
      chk({15'h0000, conv_busy}, 16'h0001, "converting");
      for (int i = 0; i < 20 && r !== 8'hFF; i++) begin
         op(OP_READ, 8'h00, r);
      end
      chk({8'h00, r}, 16'h00FF, "done slots");
      chk(temperature_result, ex, "result");
      chk({15'h0000, alarm_flag}, {15'h0000, al}, "alarm");
      read_sp({1'b0, res, 5'h00, lo, up, ex[15:8], ex[7:0]});
      cmd(CMD_ALARM_SEARCH);
      op(OP_READ, 8'h00, r);
      chk({8'h00, r}, {8'h00, al ? DEV_ID[7:0] : 8'hFF}, "alarm search");
   endtask : run_case

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      logic [31:0] q;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      chk(temperature_result, 16'h0000, "result after reset");
      chk({14'h0000, alarm_flag, conv_busy}, 16'h0000, "idle after reset");
      av_xfer(1'b1, 4'hC, 32'hFFFF_FFFF, q);
      av_xfer(1'b0, 4'h8, 32'h0, q);
      chk(q[31:16] | q[15:0], 16'h0000, "unmapped read");
      read_sp({1'b0, 2'b11, 5'h00, 8'h80, 8'h7F, 16'h0000});
      for (int c = 0; c < 7; c++) begin
         run_case(SV[c], RS[c], UP[c], LO[c]);
      end
      conclude();
   end
endmodule : temp_convert_alarm_tb
